//--- inc/fcsp_pkg.sv
// Functional notes
// - Every reset reloads the protection register from its nonvolatile image.
// - With protection enabled, software may only lower protect-select, raising protection.
// - With protection disabled, software writes leave the protection setting unchanged.
// - Debug writes change protection bits freely, bypassing the software restriction.
// - Protect-select in bits 7:1 sets top-end boundary; protected locations never erased/programmed.
// - Bit 0 disables protection; at 0 the selected top region is protected.
// - Writing one to buffer-empty launches and clears it; transfer of the buffer to the array sets it again.
// - Only burst program buffers; buffer-empty shows whether another burst fits.
// - Complete flag sets when idle and buffer empty; clears on launch; ignores writes.
// - Violation flag sets on protected-location attempt; command ignored; write one clears.
// - Access error on bad sequence, unwritten divider, or stop mid-command; write one clears.
// - Blank flag set after all-erased blank check; cleared on next valid launch.
// - Five codes recognised, including blank check, byte program, burst program.
// - Page erase covers 512 bytes; mass erase covers the whole array.
// - Any other code raises access error and is not executed.
// - Successful blank check sets the security state code to unsecured.
// - Flash clock is bus clock, optionally divided by eight, over divider plus one.
package fcsp_pkg;
   localparam int ADDR_W = 16;
   localparam logic [3:0] REG_PROT = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_CMD = 4'h2;
   localparam logic [3:0] REG_DIV = 4'h3;
   localparam logic [3:0] REG_ADDRL = 4'h4;
   localparam logic [3:0] REG_ADDRH = 4'h5;
   localparam logic [3:0] REG_DATA = 4'h6;
   localparam logic [3:0] REG_IMASK = 4'h7;
   localparam logic [3:0] REG_SEC = 4'h8;
   localparam int ST_CBEF = 7;
   localparam int ST_CCF = 6;
   localparam int ST_PVIOL = 5;
   localparam int ST_ACCERR = 4;
   localparam int ST_BLANK = 2;
   localparam int DIV_PRESCALE = 6;
   localparam int DIV_WRITTEN = 7;
   localparam logic [7:0] CMD_BLANK = 8'h05;
   localparam logic [7:0] CMD_BYTE = 8'h20;
   localparam logic [7:0] CMD_BURST = 8'h25;
   localparam logic [7:0] CMD_PAGE = 8'h40;
   localparam logic [7:0] CMD_MASS = 8'h41;
   localparam logic [ADDR_W-1:0] PAGE_MASK = 16'hFE00;
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [7:0] STAT_RESET = 8'hC0;
   localparam logic [2:0] PRESCALE_DIV = 3'h7;
   localparam logic [4:0] PROT_SHIFT = 5'h9;
   typedef enum logic [1:0] {FCSP_IDLE, FCSP_WAIT_ARRAY, FCSP_LOAD} fcsp_state_t;
endpackage

//--- rtl/fcsp_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_clock_divider
   import fcsp_pkg::*;
(
   input wire logic sys_clk, // Bus clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic prescaleByEight, // Extra divide by eight
   input wire logic [5:0] divider, // Divide by value plus one
   output logic flashTick // One pulse per flash clock
);
   typedef struct packed {
      logic [2:0] pre;
      logic [5:0] cnt;
      logic tick;
   } fcsp_div_t;
   fcsp_div_t cur, next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.tick = 1'b0;
      if (!prescaleByEight || cur.pre == PRESCALE_DIV) begin
         next_cur.pre = 3'h0;
         if (cur.cnt >= divider) begin
            next_cur.cnt = 6'h00;
            next_cur.tick = 1'b1;
         end else begin
            next_cur.cnt = cur.cnt + 6'h01;
         end
      end else begin
         next_cur.pre = cur.pre + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign flashTick = cur.tick;
endmodule
`default_nettype wire

//--- rtl/fcsp_flash_control.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_flash_control
   import fcsp_pkg::*;
(
   input wire logic sys_clk, // Bus clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic [3:0] regAddr, // Register index
   input wire logic [7:0] regWrData, // Write data
   input wire logic regWrite, // Write strobe
   input wire logic regRead, // Read strobe
   output logic [7:0] regRdData, // Read data, cycle after strobe
   input wire logic debugWrite, // Background debug write of protection
   input wire logic [7:0] debugData, // Debug protection value
   input wire logic [7:0] nonvolatileProtectionImage, // Protection image from flash
   input wire logic stopRequest, // Stop mode entry
   output logic flashTick, // Internal flash clock pulse
   output logic arrayStart, // Command pulse to array
   output logic [7:0] arrayCommand, // Command code
   output logic [ADDR_W-1:0] arrayAddress, // Target address
   output logic [7:0] arrayData, // Program data
   input wire logic arrayDone, // Array finished command
   input wire logic arrayBlankResult, // Blank check found all 0xFF
   output logic [1:0] securityStateCode, // Security state
   output logic irq // Level interrupt
);
   typedef struct packed {
      logic [7:0] prot;
      logic cbef;
      logic ccf;
      logic pviol;
      logic accerr;
      logic blank;
      logic [7:0] cmd;
      logic [7:0] div;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic [7:0] imask;
      logic [1:0] sec;
      logic bufValid;
      logic [7:0] bufCmd;
      logic [ADDR_W-1:0] bufAddr;
      logic [7:0] bufData;
      logic active;
      logic [7:0] actCmd;
      logic start;
      logic [ADDR_W-1:0] outAddr;
      logic [7:0] outData;
      logic [7:0] rd;
      logic protLoaded;
      fcsp_state_t state;
   } fcsp_ctl_t;
   fcsp_ctl_t cur, next_cur;

   logic [7:0] statusByte;
   logic [ADDR_W-1:0] protBoundary;
   logic cmdLegal;
   logic cmdProtected;
   logic [7:0] irqEvents;

   fcsp_clock_divider divider_i (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .prescaleByEight(cur.div[DIV_PRESCALE]),
      .divider(cur.div[5:0]),
      .flashTick(flashTick)
   );

   always_comb begin
      statusByte = 8'h00;
      statusByte[ST_CBEF] = cur.cbef;
      statusByte[ST_CCF] = cur.ccf;
      statusByte[ST_PVIOL] = cur.pviol;
      statusByte[ST_ACCERR] = cur.accerr;
      statusByte[ST_BLANK] = cur.blank;
   end

   // Region from boundary to top of flash is protected
   assign protBoundary = ADDR_W'({cur.prot[7:1], 1'b1} + 8'h01) << PROT_SHIFT;
   assign cmdLegal = cur.cmd == CMD_BLANK || cur.cmd == CMD_BYTE || cur.cmd == CMD_BURST
      || cur.cmd == CMD_PAGE || cur.cmd == CMD_MASS;
   always_comb begin
      cmdProtected = 1'b0;
      if (!cur.prot[0]) begin
         if (cur.cmd == CMD_MASS) begin
            cmdProtected = 1'b1;
         end else if (cur.cmd == CMD_PAGE) begin
            cmdProtected = (cur.addr & PAGE_MASK) >= protBoundary || protBoundary == '0;
         end else if (cur.cmd != CMD_BLANK) begin
            cmdProtected = cur.addr >= protBoundary || protBoundary == '0;
         end
      end
   end
   assign irqEvents = statusByte & cur.imask;
   assign irq = |irqEvents;

   always_comb begin
      next_cur = cur;
      next_cur.start = 1'b0;
      next_cur.rd = 8'h00;
      if (!cur.protLoaded) begin
         next_cur.prot = nonvolatileProtectionImage;
         next_cur.protLoaded = 1'b1;
      end
      if (regRead) begin
         case (regAddr)
            REG_PROT: next_cur.rd = cur.prot;
            REG_STAT: next_cur.rd = statusByte;
            REG_CMD: next_cur.rd = cur.cmd;
            REG_DIV: next_cur.rd = cur.div;
            REG_ADDRL: next_cur.rd = cur.addr[7:0];
            REG_ADDRH: next_cur.rd = cur.addr[15:8];
            REG_DATA: next_cur.rd = cur.data;
            REG_IMASK: next_cur.rd = cur.imask;
            REG_SEC: next_cur.rd = {6'h00, cur.sec};
            default: next_cur.rd = 8'h00;
         endcase
      end
      if (debugWrite) begin
         next_cur.prot = debugData;
      end else if (regWrite && regAddr == REG_PROT && cur.protLoaded) begin
         // Disabled stays disabled; enabled only tightens
         if (!cur.prot[0] && regWrData[0] == 1'b0 && regWrData[7:1] < cur.prot[7:1]) begin
            next_cur.prot = regWrData;
         end
      end
      if (regWrite) begin
         case (regAddr)
            REG_CMD: next_cur.cmd = regWrData;
            REG_DIV: next_cur.div = {1'b1, regWrData[6:0]};
            REG_ADDRL: next_cur.addr[7:0] = regWrData;
            REG_ADDRH: next_cur.addr[15:8] = regWrData;
            REG_DATA: next_cur.data = regWrData;
            REG_IMASK: next_cur.imask = regWrData;
            default: ;
         endcase
      end
      // Write one to clear; a same-cycle set below wins
      if (regWrite && regAddr == REG_STAT) begin
         if (regWrData[ST_PVIOL]) next_cur.pviol = 1'b0;
         if (regWrData[ST_ACCERR]) next_cur.accerr = 1'b0;
         if (regWrData[ST_CBEF] && cur.cbef) begin
            if (!cur.div[DIV_WRITTEN] || !cmdLegal) begin
               next_cur.accerr = 1'b1;
            end else if (cur.active && (cur.actCmd != CMD_BURST || cur.cmd != CMD_BURST)) begin
               next_cur.accerr = 1'b1;
            end else if (cmdProtected) begin
               next_cur.pviol = 1'b1;
            end else begin
               next_cur.blank = 1'b0;
               next_cur.ccf = 1'b0;
               next_cur.bufValid = 1'b1;
               next_cur.bufCmd = cur.cmd;
               next_cur.bufAddr = cur.addr;
               next_cur.bufData = cur.data;
               next_cur.cbef = 1'b0;
            end
         end
      end
      if (stopRequest && (cur.active || cur.bufValid)) begin
         next_cur.accerr = 1'b1;
      end
      case (cur.state)
         FCSP_IDLE: begin
            if (cur.bufValid) begin
               next_cur.state = FCSP_LOAD;
            end
         end
         FCSP_LOAD: begin
            // Buffer moves to array; buffer free again
            next_cur.start = 1'b1;
            next_cur.active = 1'b1;
            next_cur.actCmd = cur.bufCmd;
            next_cur.outAddr = cur.bufAddr;
            next_cur.outData = cur.bufData;
            next_cur.bufValid = 1'b0;
            next_cur.cbef = 1'b1;
            next_cur.state = FCSP_WAIT_ARRAY;
         end
         FCSP_WAIT_ARRAY: begin
            if (arrayDone) begin
               next_cur.active = 1'b0;
               if (cur.actCmd == CMD_BLANK && arrayBlankResult) begin
                  next_cur.blank = 1'b1;
                  next_cur.sec = SEC_UNSECURED;
               end
               next_cur.state = (cur.bufValid || next_cur.bufValid) ? FCSP_LOAD : FCSP_IDLE;
            end
         end
         default: next_cur.state = FCSP_IDLE;
      endcase
      if (!next_cur.active && !next_cur.bufValid && next_cur.cbef) begin
         next_cur.ccf = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cur <= '0;
         cur.cbef <= STAT_RESET[ST_CBEF];
         cur.ccf <= STAT_RESET[ST_CCF];
         cur.state <= FCSP_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   assign regRdData = cur.rd;
   assign arrayStart = cur.start;
   assign arrayCommand = cur.actCmd;
   assign arrayAddress = cur.outAddr;
   assign arrayData = cur.outData;
   assign securityStateCode = cur.sec;
endmodule
`default_nettype wire

//--- testbench/fcsp_flash_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_flash_control_checker
   import fcsp_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [3:0] regAddr, // Index
   input wire logic [7:0] regWrData, // Write data
   input wire logic regWrite, // Write strobe
   input wire logic regRead, // Read strobe
   input wire logic [7:0] regRdData, // Read data
   input wire logic arrayStart, // Array start
   input wire logic [7:0] arrayCommand, // Array code
   input wire logic [1:0] securityStateCode, // Security
   input wire logic irq // Interrupt
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   logic [7:0] lastCmd;
   logic legalCmd;
   logic launch;
   assign legalCmd = lastCmd inside {CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS};
   assign launch = regWrite && regAddr == REG_STAT && regWrData[ST_CBEF];
   always_ff @(posedge sys_clk) begin
      if (regWrite && regAddr == REG_CMD) begin
         lastCmd <= regWrData;
      end
   end
   sequence s_launch; launch; endsequence
   sequence s_peek; regRead && regAddr == REG_STAT; endsequence
   // An accepted launch from idle reaches the array two edges after the status peek
   sequence s_peek_start; s_peek ##2 arrayStart; endsequence
   property p_reset_quiet; $fell(sys_rst) |-> regRdData == 8'h00 && !irq && securityStateCode == 2'h0; endproperty
   property p_code_legal; arrayStart |-> legalCmd; endproperty
   property p_cmd_match; arrayStart |-> arrayCommand == lastCmd; endproperty
   property p_illegal_ignored; s_launch ##0 !legalCmd |=> !arrayStart [*3]; endproperty
   // Idle start takes three edges: buffer, load, start
   property p_start_after_launch; arrayStart && arrayCommand != CMD_BURST |-> $past(launch, 3); endproperty
   property p_launch_flags; s_launch ##1 s_peek_start |-> $past(regRdData[7:6]) == 2'b00; endproperty
   property p_one_at_array; arrayStart |=> !arrayStart; endproperty
   property p_sec_unsecured; $changed(securityStateCode) |-> securityStateCode == SEC_UNSECURED; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
   a_code_legal: assert property (p_code_legal) else $error("unknown code sent to array");
   a_cmd_match: assert property (p_cmd_match) else $error("array code differs from command");
   a_illegal_ignored: assert property (p_illegal_ignored) else $error("illegal code executed");
   a_start_after_launch: assert property (p_start_after_launch) else $error("start without launch");
   a_launch_flags: assert property (p_launch_flags) else $error("flags not cleared on launch");
   a_one_at_array: assert property (p_one_at_array) else $error("two starts in a row");
   a_sec_unsecured: assert property (p_sec_unsecured) else $error("bad security change");
endmodule
bind fcsp_flash_control fcsp_flash_control_checker i_fcsp_flash_control_checker (.sys_clk, .sys_rst, .regAddr,
   .regWrData, .regWrite, .regRead, .regRdData, .arrayStart, .arrayCommand, .securityStateCode, .irq);
`default_nettype wire

//--- testbench/fcsp_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_array_model
   import fcsp_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic arrayStart, // Start pulse
   input wire logic [7:0] arrayCommand, // Code
   output logic arrayDone, // Done pulse
   output logic arrayBlankResult // Blank outcome
);
   logic [5:0] busyCnt;
   // Byte program quick, others slow enough to buffer a burst
   always_ff @(posedge sys_clk) begin
      arrayDone <= 1'b0;
      if (sys_rst) begin
         busyCnt <= 6'h00;
      end else if (arrayStart) begin
         busyCnt <= (arrayCommand == CMD_BYTE) ? 6'h03 : 6'h28;
      end else if (busyCnt != 6'h00) begin
         busyCnt <= busyCnt - 6'h01;
         arrayDone <= busyCnt == 6'h01;
      end
   end
   // Outside done the result toggles, so nothing may rely on it
   assign arrayBlankResult = arrayDone ? arrayCommand == CMD_BLANK : busyCnt[0];
endmodule
`default_nettype wire

//--- testbench/flash_command_status_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_command_status_protect_tb
   import fcsp_pkg::*;
;
   typedef struct packed {logic [7:0] code; logic [15:0] addr; logic [7:0] st;} fcsp_case_t;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, debugData = 8'h00;
   logic regWrite = 1'b0, regRead = 1'b0, debugWrite = 1'b0, stopRequest = 1'b0;
   logic [7:0] regRdData, arrayCommand, arrayData, d;
   logic [ADDR_W-1:0] arrayAddress;
   logic [1:0] securityStateCode;
   logic flashTick, arrayStart, arrayDone, arrayBlankResult, irq;
   int mismatches = 0;
   int cmp_count = 0;
   // Image protects 0xFC00 up; after lowering, 0xF800 up. Blank check only unlocks security
   fcsp_case_t cases [9] = '{'{CMD_BLANK, 16'h1000, 8'hC4}, '{CMD_BYTE, 16'h1000, 8'hC0},
      '{CMD_BURST, 16'h1000, 8'hC0}, '{CMD_PAGE, 16'h1000, 8'hC0}, '{CMD_MASS, 16'h1000, 8'hE0},
      '{8'h30, 16'h1000, 8'hD0}, '{CMD_BYTE, 16'hF7FF, 8'hC0}, '{CMD_BYTE, 16'hF800, 8'hE0},
      '{CMD_PAGE, 16'hF800, 8'hE0}};
   fcsp_flash_control i_fcsp_flash_control (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead,
      .regRdData, .debugWrite, .debugData, .nonvolatileProtectionImage(8'h7C), .stopRequest, .flashTick,
      .arrayStart, .arrayCommand, .arrayAddress, .arrayData, .arrayDone, .arrayBlankResult, .securityStateCode, .irq);
   fcsp_array_model i_fcsp_array_model (.sys_clk, .sys_rst, .arrayStart, .arrayCommand, .arrayDone,
      .arrayBlankResult);
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Idle cycle after each access keeps one assignment per strobe per step
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 v = regRdData;
      @(posedge sys_clk);
   endtask
   // Launch followed at once by a status read
   task automatic cmd(input logic [7:0] c, input logic [15:0] a);
      wr(REG_CMD, c);
      wr(REG_ADDRL, a[7:0]);
      wr(REG_ADDRH, a[15:8]);
      wr(REG_DATA, 8'h5A);
      regAddr <= REG_STAT;
      regWrData <= 8'h80;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic waitCcf();
      for (int i = 0; i < 100; i++) begin
         rd(REG_STAT, d);
         if (d[ST_CCF] === 1'b1) return;
      end
      mismatches++;
      test_done();
   endtask
   // Cycles from one flash tick to the next, sampled mid-cycle
   task automatic tickGap(output logic [7:0] gap);
      gap = 8'h00;
      for (int i = 0; i < 100; i++) begin
         @(negedge sys_clk);
         if (flashTick === 1'b1) break;
      end
      for (int i = 0; i < 100; i++) begin
         @(negedge sys_clk);
         gap++;
         if (flashTick === 1'b1) break;
      end
      @(posedge sys_clk);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(REG_PROT, d);
      check("prot image", d, 8'h7C);
      rd(REG_STAT, d);
      check("status reset", d, STAT_RESET);
      wr(REG_PROT, 8'h7E);
      rd(REG_PROT, d);
      check("prot raise", d, 8'h7C);
      wr(REG_PROT, 8'h7A);
      rd(REG_PROT, d);
      check("prot lower", d, 8'h7A);
      wr(REG_IMASK, 8'h10);
      cmd(CMD_BYTE, 16'h1000);
      rd(REG_STAT, d);
      check("no divider", d, 8'hD0);
      check("irq set", {7'h00, irq}, 8'h01);
      wr(REG_IMASK, 8'h00);
      check("irq masked", {7'h00, irq}, 8'h00);
      wr(REG_STAT, 8'h10);
      rd(REG_STAT, d);
      check("accerr clear", d, 8'hC0);
      wr(REG_DIV, 8'h04);
      for (int k = 0; k < 9; k++) begin
         cmd(cases[k].code, cases[k].addr);
         waitCcf();
         check("command status", d, cases[k].st);
         wr(REG_STAT, 8'h30);
         rd(REG_STAT, d);
         check("flags clear", d, cases[k].st & 8'hC4);
      end
      check("security", {6'h00, securityStateCode}, {6'h00, SEC_UNSECURED});
      cmd(CMD_BURST, 16'h2000);
      cmd(CMD_BURST, 16'h2001);
      rd(REG_STAT, d);
      check("buffer full", d, 8'h00);
      waitCcf();
      check("burst done", d, 8'hC0);
      check("array addr low", arrayAddress[7:0], 8'h01);
      check("array addr high", arrayAddress[15:8], 8'h20);
      check("array data", arrayData, 8'h5A);
      cmd(CMD_PAGE, 16'h3000);
      stopRequest <= 1'b1;
      @(posedge sys_clk);
      stopRequest <= 1'b0;
      waitCcf();
      check("stop in command", d, 8'hD0);
      debugData <= 8'h01;
      debugWrite <= 1'b1;
      @(posedge sys_clk);
      debugWrite <= 1'b0;
      wr(REG_PROT, 8'h00);
      rd(REG_PROT, d);
      check("debug prot", d, 8'h01);
      rd(4'hF, d);
      check("unmapped", d, 8'h00);
      tickGap(d);
      check("tick gap", d, 8'h05);
      wr(REG_DIV, 8'h41);
      rd(REG_DIV, d);
      check("divider", d, 8'hC1);
      tickGap(d);
      tickGap(d);
      check("tick gap prescaled", d, 8'h10);
      // Second reset must undo the debug write
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(REG_PROT, d);
      check("prot reload", d, 8'h7C);
      rd(REG_STAT, d);
      check("status after reset", d, STAT_RESET);
      test_done();
   end
endmodule
`default_nettype wire
